/* File: verilog/sadc_defs.svh */
// constants for the successive approximation converter control block
//==================================================================
// Summary of operation
// - start bit write begins conversion, clears when done
// - channel change mid-conversion waits for completion
// - trigger rising edge resets prescaler, starts conversion
// - edges while busy ignored; held trigger never restarts
// - flag trigger ignores the flag; next conversion starts at completion
// - sync pulse starts conversion; single-shot blocks until high read
// - flag trigger runs back-to-back; first started by software
// - start bit reads one while busy; starts under auto
// - ten-bit result right aligned, left when adjusted
// - low byte read locks results until high read
// - complete flag set even when result discarded
// - prescaler divides by select, held reset while disabled
// - software start waits for next converter clock rising edge
// - conversion lasts 13 cycles, first one 25
// - sample at 3.5 cycles, first conversion 13.5
// - completion writes result, sets flag, clears start
// - trigger edge delayed three cpu clocks by synchroniser
// - auto conversion samples at 4, lasts 16
// - free running restarts immediately, start bit stays set
// - reference selection follows buffer even when disabled
// - conversions only while enabled; clearing stops converter
// - selection frozen during conversion, resumes last cycle
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH

//==================================================================
// register byte offsets
`define SADC_OFS_CTRL_A   5'h00
`define SADC_OFS_CTRL_B   5'h04
`define SADC_OFS_INSEL    5'h08
`define SADC_OFS_RES_LO   5'h0c
`define SADC_OFS_RES_HI   5'h10
`define SADC_OFS_STATUS   5'h14

//==================================================================
// field positions, control register a
`define SADC_A_EN         7
`define SADC_A_START      6
`define SADC_A_AUTO       5
`define SADC_A_FLAG       4
// control register b
`define SADC_B_SSHOT      7
// input select register
`define SADC_S_LEFT       5

//==================================================================
// reset values
`define SADC_RST_BYTE     8'h00
`define SADC_RST_SEL      8'h00

//==================================================================
// trigger sources
`define SADC_TS_FREE      3'h0
`define SADC_TS_SYNC      3'h7

//==================================================================
// timing in converter half cycles
`define SADC_HC_SH_NORM   7'd7
`define SADC_HC_SH_FIRST  7'd27
`define SADC_HC_SH_AUTO   7'd8
`define SADC_HC_END_NORM  7'd26
`define SADC_HC_END_FIRST 7'd50
`define SADC_HC_END_AUTO  7'd32
// cpu cycles of trigger synchronisation
`define SADC_SYNC_CYC     3

`endif

/* File: verilog/sadc_pkg.sv */
// types shared by the converter control block
package sadc_pkg;

  // sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_CONV} sadc_state_t;

  // kind of conversion in progress
  typedef enum logic [1:0] {K_NORM, K_FIRST, K_AUTO} sadc_kind_t;

  // channel and reference selection handed to the analog side
  typedef struct packed {
    logic [1:0] ref_sel;   // reference_select_bits
    logic       left;      // left_adjust_bit
    logic [4:0] chan;      // channel_select_bits
  } sadc_sel_t;

  // prescaler state
  typedef struct packed {
    logic [6:0] cnt;
  } sadc_psc_t;

endpackage

/* File: verilog/sadc_prescaler.sv */
// converter clock prescaler producing rise and fall tick pulses
`timescale 1ns/1ps
`default_nettype none
module sadc_prescaler
  import sadc_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rst_b_in,
  // control
  input  wire logic       run_in,
  input  wire logic [2:0] sel_in,
  // converter clock edges
  output logic            rise_out,
  output logic            fall_out
);

  sadc_psc_t  s_r;   // counter state
  sadc_psc_t  s_nxt; // next counter state
  logic [7:0] div;   // division ratio
  logic [6:0] last;  // terminal count
  logic [6:0] half;  // mid count

  //==================================================================
  // division ratio: select 0 and 1 both divide by two
  always_comb
  begin
    div   = 8'h01 << ((sel_in == 3'h0) ? 3'h1 : sel_in);
    last  = 7'(div - 8'h01);
    half  = 7'((div >> 1) - 8'h01);
    s_nxt = s_r;
    // held at zero while not running
    if (!run_in)
      s_nxt.cnt = 7'h00;
    else if (s_r.cnt == last)
      s_nxt.cnt = 7'h00;
    else
      s_nxt.cnt = 7'(s_r.cnt + 7'h01);
    rise_out = run_in && (s_r.cnt == last);
    fall_out = run_in && (s_r.cnt == half);
  end

  //==================================================================
  // state register
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

endmodule
`default_nettype wire

/* File: verilog/sadc_ctrl.sv */
// conversion control for the ten-bit successive approximation converter
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sadc_defs.svh"
module sadc_ctrl
  import sadc_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_b_in,
  // avalon-mm slave
  input  wire logic [4:0]  address_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [31:0] writedata_in,
  input  wire logic [3:0]  byteenable_in,
  output logic [31:0]      readdata_out,
  output logic             waitrequest_out,
  // trigger sources, index by trigger_select_field
  input  wire logic [7:0]  trig_src_in,
  // comparator array result
  input  wire logic [9:0]  conv_result_in,
  // analog side controls
  output logic             analog_power_out,
  output sadc_sel_t        analog_sel_out,
  output logic             sample_hold_out,
  output logic             conv_busy_out,
  output logic             conv_done_out
);

  //==================================================================
  // block state, all in one struct
  typedef struct packed {
    sadc_state_t st;       // sequencer state
    sadc_kind_t  kind;     // kind of running conversion
    logic [6:0]  hc;       // converter half cycles since start
    logic        en;       // converter_enable
    logic        auto_en;  // auto_trigger_enable
    logic        flag;     // conv_complete_flag
    logic [2:0]  ps;       // prescaler_select_field
    logic        sshot;    // sync_single_shot_enable
    logic [2:0]  ts;       // trigger_select_field
    sadc_sel_t   sel;      // buffered input_select_reg
    sadc_sel_t   act;      // selection seen by the analog side
    logic [7:0]  res_lo;   // result_low_byte
    logic [7:0]  res_hi;   // result_high_byte
    logic        lock;     // result bytes locked
    logic        sblk;     // sync trigger blocked
    logic        first;    // next conversion is the first
    logic        trig_d;   // trigger of last cycle
    logic [`SADC_SYNC_CYC-1:0] pipe; // trigger synchroniser
    logic        ack;      // bus answer cycle
    logic [7:0]  rdata;    // read data byte
    logic        sh;       // sample-and-hold pulse
    logic        done;     // completion pulse
  } sadc_regs_t;

  sadc_regs_t s_r;        // registered state
  sadc_regs_t s_nxt;      // next state
  logic       psc_rise;   // converter clock rising edge
  logic       psc_fall;   // converter clock falling edge
  logic       psc_clr;    // trigger resets the prescaler
  logic       busy;       // conversion pending or running
  logic       trig;       // selected trigger level
  logic       edge_ok;    // accepted trigger edge
  logic       wr_go;      // write takes effect this edge
  logic       rd_go;      // read side effects this edge
  logic [6:0] hc_inc;     // incremented half-cycle count
  logic [6:0] sh_pt;      // sample point of current kind
  logic [6:0] end_pt;     // end point of current kind
  logic       evt;        // any converter clock edge
  logic       is_end;     // conversion ends this edge
  logic [7:0] wb;         // written low byte

  //==================================================================
  // prescaler; free runs while enabled, cleared by triggers
  sadc_prescaler u_psc
  (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .run_in     (s_r.en && !psc_clr),
    .sel_in     (s_r.ps),
    .rise_out   (psc_rise),
    .fall_out   (psc_fall)
  );

  //==================================================================
  // next-state logic
  always_comb
  begin
    s_nxt   = s_r;
    busy    = (s_r.st != ST_IDLE) || (s_r.pipe != '0);
    trig    = trig_src_in[s_r.ts];
    wr_go   = write_in && s_r.ack && byteenable_in[0];
    rd_go   = read_in && s_r.ack;
    wb      = writedata_in[7:0];
    evt     = psc_rise || psc_fall;
    hc_inc  = 7'(s_r.hc + 7'd1);
    is_end  = 1'b0;
    // one pulse per event only
    s_nxt.sh     = 1'b0;
    s_nxt.done   = 1'b0;
    s_nxt.trig_d = trig;

    // timing points of the running kind
    case (s_r.kind)
      K_FIRST:
      begin
        sh_pt  = `SADC_HC_SH_FIRST;
        end_pt = `SADC_HC_END_FIRST;
      end
      K_AUTO:
      begin
        sh_pt  = `SADC_HC_SH_AUTO;
        end_pt = `SADC_HC_END_AUTO;
      end
      default:
      begin
        sh_pt  = `SADC_HC_SH_NORM;
        end_pt = `SADC_HC_END_NORM;
      end
    endcase

    //================================================================
    // bus: one wait state, answer on the second cycle
    s_nxt.ack = (read_in || write_in) && !s_r.ack;
    if (read_in && !s_r.ack)
    begin
      case (address_in)
        `SADC_OFS_CTRL_A:
          s_nxt.rdata = {s_r.en, busy, s_r.auto_en,
                         s_r.flag, 1'b0, s_r.ps};
        `SADC_OFS_CTRL_B:
          s_nxt.rdata = {s_r.sshot, 4'h0, s_r.ts};
        `SADC_OFS_INSEL:
          s_nxt.rdata = s_r.sel;
        `SADC_OFS_RES_LO:
          s_nxt.rdata = s_r.res_lo;
        `SADC_OFS_RES_HI:
          s_nxt.rdata = s_r.res_hi;
        `SADC_OFS_STATUS:
          s_nxt.rdata = {5'h00, s_r.first, s_r.sblk, s_r.lock};
        default:
          s_nxt.rdata = `SADC_RST_BYTE; // unmapped reads zero
      endcase
    end

    // read side effects on the result pair
    if (rd_go && (address_in == `SADC_OFS_RES_LO))
      s_nxt.lock = 1'b1;
    if (rd_go && (address_in == `SADC_OFS_RES_HI))
    begin
      s_nxt.lock = 1'b0;
      s_nxt.sblk = 1'b0;
    end

    // register writes
    if (wr_go)
    begin
      case (address_in)
        `SADC_OFS_CTRL_A:
        begin
          s_nxt.en      = wb[`SADC_A_EN];
          s_nxt.auto_en = wb[`SADC_A_AUTO];
          s_nxt.ps      = wb[2:0];
          // write one clears; a same-cycle completion still sets
          if (wb[`SADC_A_FLAG])
            s_nxt.flag = 1'b0;
          // start only when enabled and quiet
          if (wb[`SADC_A_START] && s_r.en && !busy)
            s_nxt.st = ST_ARM;
        end
        `SADC_OFS_CTRL_B:
        begin
          s_nxt.sshot = wb[`SADC_B_SSHOT];
          s_nxt.ts    = wb[2:0];
        end
        `SADC_OFS_INSEL:
          s_nxt.sel = wb;
        default:
        begin
          // result and status are read only; unmapped ignored
        end
      endcase
    end

    //================================================================
    // auto trigger: edge detect then three-cycle synchroniser
    edge_ok = s_r.en && s_r.auto_en && trig && !s_r.trig_d
              && !busy && (s_r.ts != `SADC_TS_FREE)
              && !((s_r.ts == `SADC_TS_SYNC) && s_r.sblk);
    s_nxt.pipe = {s_r.pipe[`SADC_SYNC_CYC-2:0], edge_ok};

    //================================================================
    // conversion sequencer
    case (s_r.st)
      ST_IDLE:
      begin
        // synchronised trigger: clear prescaler, start at once
        if (s_r.pipe[`SADC_SYNC_CYC-1])
        begin
          s_nxt.st   = ST_CONV;
          s_nxt.hc   = 7'd0;
          s_nxt.kind = s_r.first ? K_FIRST : K_AUTO;
          s_nxt.first = 1'b0;
        end
      end
      ST_ARM:
      begin
        // software start waits for the next converter rise
        if (psc_rise)
        begin
          s_nxt.st    = ST_CONV;
          s_nxt.hc    = 7'd0;
          s_nxt.kind  = s_r.first ? K_FIRST : K_NORM;
          s_nxt.first = 1'b0;
        end
      end
      ST_CONV:
      begin
        if (evt)
        begin
          s_nxt.hc = hc_inc;
          if (hc_inc == sh_pt)
            s_nxt.sh = 1'b1;
          if (hc_inc == end_pt)
            is_end = 1'b1;
        end
      end
      default:
        s_nxt.st = ST_IDLE;
    endcase

    // completion: result, flag, start bit falls with state
    if (is_end)
    begin
      s_nxt.done = 1'b1;
      s_nxt.flag = 1'b1;
      // locked pair keeps the older result
      if (!s_r.lock)
      begin
        if (s_r.act.left)
        begin
          s_nxt.res_hi = conv_result_in[9:2];
          s_nxt.res_lo = {conv_result_in[1:0], 6'h00};
        end
        else
        begin
          s_nxt.res_hi = {6'h00, conv_result_in[9:8]};
          s_nxt.res_lo = conv_result_in[7:0];
        end
      end
      if (s_r.auto_en && (s_r.ts == `SADC_TS_SYNC) && s_r.sshot)
        s_nxt.sblk = 1'b1;
      // flag as trigger: restart right away, flag ignored
      if (s_r.auto_en && (s_r.ts == `SADC_TS_FREE))
      begin
        s_nxt.st   = ST_CONV;
        s_nxt.hc   = 7'd0;
        s_nxt.kind = K_NORM;
      end
      else
        s_nxt.st = ST_IDLE;
    end

    //================================================================
    // selection follows the buffer except inside a conversion;
    // the last converter cycle reopens it for the next one
    if ((s_r.st != ST_CONV) || (s_r.hc >= 7'(end_pt - 7'd2)))
      s_nxt.act = s_nxt.sel;

    //================================================================
    // disable wins over everything: stop and rearm first conversion
    if (!s_nxt.en)
    begin
      s_nxt.st    = ST_IDLE;
      s_nxt.pipe  = '0;
      s_nxt.first = 1'b1;
      s_nxt.hc    = 7'd0;
    end
  end

  //==================================================================
  // state register
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s_r       <= '0;
      s_r.st    <= ST_IDLE;
      s_r.kind  <= K_NORM;
      s_r.first <= 1'b1;
      s_r.sel   <= `SADC_RST_SEL;
      s_r.act   <= `SADC_RST_SEL;
    end
    else
      s_r <= s_nxt;
  end

  //==================================================================
  // outputs
  // kept out of the next-state process so no loop runs through the prescaler
  assign psc_clr          = (s_r.st == ST_IDLE)
                            && s_r.pipe[`SADC_SYNC_CYC-1];
  assign readdata_out     = {24'h000000, s_r.rdata};
  assign waitrequest_out  = (read_in || write_in) && !s_r.ack;
  assign analog_power_out = s_r.en;
  assign analog_sel_out   = s_r.act;
  assign sample_hold_out  = s_r.sh;
  assign conv_busy_out    = (s_r.st == ST_CONV);
  assign conv_done_out    = s_r.done;

endmodule
`default_nettype wire

/* File: verification/sadc_afe_model.sv */
// behavioural model of the analog multiplexer, sample-and-hold and comparator
`timescale 1ns/1ps
`default_nettype none
module sadc_afe_model
  import sadc_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rst_b_in,
  // from the control block
  input  wire logic       sample_hold_in,
  input  wire logic       conv_busy_in,
  // analog level seen on the selected channel
  input  wire logic [9:0] level_in,
  // comparator array result
  output logic [9:0]      result_out
);
  //====
  // held sample and a toggle for the idle pattern
  logic [9:0] held_r;  // level frozen at the sample point
  logic       tog_r;   // flips every cycle

  // capture at the sample pulse only, like a real hold capacitor
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      held_r <= 10'h000;
      tog_r  <= 1'b0;
    end
    else
    begin
      tog_r <= ~tog_r;
      if (sample_hold_in)
        held_r <= level_in;
    end
  end

  // outside a conversion the array output is junk that keeps changing,
  // so a controller latching at the wrong moment gets a wrong code
  assign result_out = conv_busy_in ? held_r
                    : (tog_r ? ~held_r : held_r ^ 10'h2aa);
endmodule
`default_nettype wire

/* File: verification/sadc_ctrl_asserts.sv */
// concurrent checks on the ports of the converter control block
`timescale 1ns/1ps
`default_nettype none
module sadc_ctrl_chk
  import sadc_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_b_in,
  // register bus
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [31:0] readdata_out,
  input  wire logic        waitrequest_out,
  // analog side
  input  wire logic        analog_power_out,
  input  wire sadc_sel_t   analog_sel_out,
  input  wire logic        sample_hold_out,
  input  wire logic        conv_busy_out,
  input  wire logic        conv_done_out
);
  //====
  // one domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  // at most one wait state per access
  property p_one_wait;
    (read_in || write_in) && waitrequest_out |=> !waitrequest_out;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("bus access took more than one wait state");

  // no stall without a request
  property p_idle_nowait;
    !read_in && !write_in |-> !waitrequest_out;
  endproperty
  a_idle_nowait: assert property (p_idle_nowait)
    else $error("waitrequest high with no request");

  // byte registers leave the upper read bits clear
  property p_rd_upper;
    read_in && !waitrequest_out |-> readdata_out[31:8] == 24'h000000;
  endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("read data upper bits not zero");

  // completion is a single-cycle pulse
  property p_done_pulse;
    conv_done_out |=> !conv_done_out;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done pulse longer than one cycle");

  // completion only follows a running conversion
  property p_done_cause;
    conv_done_out |-> $past(conv_busy_out) || $past(conv_busy_out, 2);
  endproperty
  a_done_cause: assert property (p_done_cause)
    else $error("done without a conversion");

  // sample pulse lies inside a conversion and lasts one cycle
  property p_sh_pulse;
    sample_hold_out |-> conv_busy_out ##1 !sample_hold_out;
  endproperty
  a_sh_pulse: assert property (p_sh_pulse)
    else $error("sample pulse outside conversion or too long");

  // even the shortest conversion spans many cpu cycles
  property p_conv_min;
    $rose(conv_busy_out) |-> conv_busy_out [*8];
  endproperty
  a_conv_min: assert property (p_conv_min)
    else $error("conversion ended too early");

  // selection frozen once a conversion has begun
  property p_sel_frozen;
    $rose(conv_busy_out) |=> $stable(analog_sel_out) [*4];
  endproperty
  a_sel_frozen: assert property (p_sel_frozen)
    else $error("selection moved during conversion");

  // powered down means nothing converts
  property p_off_idle;
    !analog_power_out [*2] |-> !conv_busy_out;
  endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("conversion running while disabled");
endmodule
`default_nettype wire

bind sadc_ctrl sadc_ctrl_chk u_chk (
  .ref_clk_in       (ref_clk_in),
  .rst_b_in         (rst_b_in),
  .read_in          (read_in),
  .write_in         (write_in),
  .readdata_out     (readdata_out),
  .waitrequest_out  (waitrequest_out),
  .analog_power_out (analog_power_out),
  .analog_sel_out   (analog_sel_out),
  .sample_hold_out  (sample_hold_out),
  .conv_busy_out    (conv_busy_out),
  .conv_done_out    (conv_done_out)
);

/* File: verification/testbench.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import sadc_pkg::*;
;
  //====
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic        av_rd = 1'b0;
  logic        av_wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic        wreq;
  logic [7:0]  trig = 8'h00;
  logic [9:0]  lvl = 10'h000;
  logic [9:0]  res;
  logic        pwr;
  sadc_sel_t   sel;
  logic        sh;
  logic        busy;
  logic        done;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          t0, sp, len;

  always #5 clk = ~clk;

  sadc_ctrl u_dut (.ref_clk_in(clk), .rst_b_in(rst_b), .address_in(adr),
    .read_in(av_rd), .write_in(av_wr), .writedata_in(wd),
    .byteenable_in(4'h1), .readdata_out(rdat), .waitrequest_out(wreq),
    .trig_src_in(trig), .conv_result_in(res), .analog_power_out(pwr),
    .analog_sel_out(sel), .sample_hold_out(sh), .conv_busy_out(busy),
    .conv_done_out(done));

  sadc_afe_model u_afe (.ref_clk_in(clk), .rst_b_in(rst_b),
    .sample_hold_in(sh), .conv_busy_in(busy), .level_in(lvl),
    .result_out(res));

  //====
  // verdict and hang guard
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ceiling well above the roughly 1000 cycles the tests need
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end

  //====
  // compare helpers
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // timing figures may land one cycle either side of the nominal count
  task automatic rng(input string nm, input int e, input int g);
    num_checks++;
    if (g < e - 1 || g > e + 1)
    begin
      n_mismatch++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  //====
  // avalon master: hold until waitrequest sampled low
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    adr   <= a;
    av_wr <= w;
    av_rd <= !w;
    wd    <= {24'h0, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    q = rdat;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    chk("bus answer", 1'b1, n < 50);
  endtask

  task automatic bwr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic brd(input logic [4:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk("register", {24'h0, e}, q);
  endtask

  // wait for busy, then time the sample point and the length
  task automatic meas();
    t0 = 0;
    sp = -1;
    len = 0;
    while (busy !== 1'b1 && t0 < 300)
    begin
      @(posedge clk);
      t0++;
    end
    while (busy === 1'b1 && len < 300)
    begin
      if (sh === 1'b1 && sp < 0)
        sp = len;
      @(posedge clk);
      len++;
    end
  endtask

  task automatic wdone();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    chk("done seen", 1'b1, n < 300);
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    trig[i] <= 1'b1;
    @(posedge clk);
    trig[i] <= 1'b0;
  endtask

  //====
  // scenarios
  task automatic t_idle();
    brd(5'h00, 8'h00);
    brd(5'h14, 8'h04);
    bwr(5'h00, 8'h40);
    repeat (60) @(posedge clk);
    chk("busy", 1'b0, busy);
    brd(5'h00, 8'h00);
    brd(5'h18, 8'h00);
    $display("t_idle done");
  endtask

  task automatic t_first();
    lvl <= 10'h2a5;
    bwr(5'h00, 8'h80);
    bwr(5'h00, 8'hc0);
    meas();
    rng("first len", 50, len);
    rng("first sample", 27, sp);
    brd(5'h00, 8'h90);
    brd(5'h0c, 8'ha5);
    brd(5'h10, 8'h02);
    $display("t_first done");
  endtask

  task automatic t_norm();
    bwr(5'h00, 8'h90);
    bwr(5'h08, 8'h20);
    lvl <= 10'h3c7;
    bwr(5'h00, 8'hc0);
    meas();
    rng("norm len", 26, len);
    rng("norm sample", 7, sp);
    brd(5'h0c, 8'hc0);
    brd(5'h14, 8'h01);
    lvl <= 10'h155;
    bwr(5'h00, 8'h90);
    bwr(5'h00, 8'hc0);
    brd(5'h00, 8'hc0);
    bwr(5'h08, 8'h21);
    wdone();
    brd(5'h00, 8'h90);
    brd(5'h10, 8'hf1);
    chk("selection", 8'h21, sel);
    bwr(5'h00, 8'h92);
    bwr(5'h00, 8'hc2);
    meas();
    rng("div4 len", 52, len);
    brd(5'h10, 8'h55);
    $display("t_norm done");
  endtask

  task automatic t_auto();
    bwr(5'h04, 8'h01);
    bwr(5'h00, 8'hb0);
    trig[1] <= 1'b1;
    meas();
    rng("sync delay", 4, t0);
    rng("auto len", 32, len);
    rng("auto sample", 8, sp);
    repeat (40) @(posedge clk);
    chk("held trigger", 1'b0, busy);
    trig[1] <= 1'b0;
    pulse(1);
    repeat (10) @(posedge clk);
    pulse(1);
    wdone();
    repeat (40) @(posedge clk);
    chk("edge in conv", 1'b0, busy);
    bwr(5'h00, 8'he0);
    wdone();
    $display("t_auto done");
  endtask

  task automatic t_free();
    bwr(5'h04, 8'h00);
    bwr(5'h08, 8'h00);
    bwr(5'h00, 8'hb0);
    repeat (60) @(posedge clk);
    chk("no self start", 1'b0, busy);
    bwr(5'h00, 8'he0);
    wdone();
    wdone();
    chk("still busy", 1'b1, busy);
    brd(5'h00, 8'hf0);
    bwr(5'h00, 8'h00);
    repeat (3) @(posedge clk);
    chk("off busy", 1'b0, busy);
    chk("off power", 1'b0, pwr);
    $display("t_free done");
  endtask

  task automatic t_sync();
    bwr(5'h04, 8'h87);
    bwr(5'h00, 8'hb0);
    pulse(7);
    wdone();
    brd(5'h14, 8'h02);
    pulse(7);
    repeat (60) @(posedge clk);
    chk("sync blocked", 1'b0, busy);
    brd(5'h10, 8'h01);
    pulse(7);
    wdone();
    $display("t_sync done");
  endtask

  //====
  // main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_idle();
    t_first();
    t_norm();
    t_auto();
    t_free();
    t_sync();
    print_verdict();
  end
endmodule
`default_nettype wire
